// *** common/uaar_pkg.sv ***
// constants for the uart automatic address recognition block
// Summary of operation
// [R1] with multiproc enabled in modes 1 to 3, flag only on match
// [R2] address compare active when multiproc enable set in modes 1 to 3, never in mode 0
// [R3] mode 1: match and valid stop needed
// [R4] given address: mask ones must equal address
// [R5] broadcast: address OR mask ones must be one
// [R6] reset clears address and mask to zero
// [R7] port 0 address and mask registers
// [R8] port 1 separate address and mask registers
// [R9] master broadcasts with all-ones address
// [R10] master sends address ninth bit one
// [R11] ninth bit zero frames never set flag with multiproc enabled in modes 1 to 3
// [R12] software clears multiproc enable for data
// [R13] match is given OR broadcast at frame end
package uaar_pkg;

    // ************************************************
    // register map
    // ************************************************
    localparam int NPORT = 2;
    localparam logic [7:0] P0_SLAVE_ADDR_OFS = 8'hA9;
    localparam logic [7:0] P0_ADDR_MASK_OFS = 8'hB9;
    localparam logic [7:0] P1_ADDR_MASK_OFS = 8'hBA;
    localparam logic [7:0] P1_SLAVE_ADDR_OFS = 8'hBB;
    localparam logic [7:0] SLAVE_ADDR_RST = 8'h00;
    localparam logic [7:0] ADDR_MASK_RST = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

    // ************************************************
    // uart modes and buffering
    // ************************************************
    localparam logic [1:0] UART_MODE0 = 2'h0;
    localparam logic [1:0] UART_MODE1 = 2'h1;
    localparam int RX_FIFO_DEPTH = 8;
    localparam int RX_WORD_W = 9; // ninth bit above the data byte

endpackage

// *** core/uaar_fifo.sv ***
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module uaar_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
    logic [AW:0] count_reg, count_next;
    logic push, pop;

    // handshakes from the fill level
    assign in_ready = (count_reg != DEPTH_C);
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointer and level update
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        count_next = count_reg;
        if (push) begin
            wr_ptr_next = (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_next = (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
        end
        if (push && !pop) begin
            count_next = count_reg + 1'b1;
        end else if (pop && !push) begin
            count_next = count_reg - 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg <= count_next;
        end
    end

    // storage, written only on a push
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

endmodule // uaar_fifo

// *** core/uaar_top.sv ***
// address filter for two multiprocessor uart receive ports
`timescale 1ns/1ps
module uaar_top
    import uaar_pkg::*;
#(
    parameter int FIFO_DEPTH = RX_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [NPORT-1:0][1:0] uart_mode,
    input wire logic [NPORT-1:0] multiproc_enable,
    input wire logic [NPORT-1:0] frame_valid,
    output logic [NPORT-1:0] frame_ready,
    input wire logic [NPORT-1:0][7:0] frame_data,
    input wire logic [NPORT-1:0] frame_bit9,
    input wire logic [NPORT-1:0] flag_clr,
    output logic [NPORT-1:0] rx_complete_flag,
    output logic [NPORT-1:0] rx_valid,
    input wire logic [NPORT-1:0] rx_ready,
    output logic [NPORT-1:0][RX_WORD_W-1:0] rx_data
);

    // ************************************************
    // special function registers
    // ************************************************
    logic [7:0] port0_slave_address_reg [NPORT];
    logic [7:0] port0_slave_address_next [NPORT];
    logic [7:0] port0_address_mask_reg [NPORT];
    logic [7:0] port0_address_mask_next [NPORT];
    logic [7:0] rdata_reg, rdata_next;

    // write decode and registered read mux
    always_comb begin
        port0_slave_address_next = port0_slave_address_reg;
        port0_address_mask_next = port0_address_mask_reg;
        rdata_next = rdata_reg;
        if (sfr_wr) begin
            case (sfr_addr)
                P0_SLAVE_ADDR_OFS: port0_slave_address_next[0] = sfr_wdata; // R7
                P0_ADDR_MASK_OFS: port0_address_mask_next[0] = sfr_wdata; // R7
                P1_SLAVE_ADDR_OFS: port0_slave_address_next[1] = sfr_wdata; // R8
                P1_ADDR_MASK_OFS: port0_address_mask_next[1] = sfr_wdata; // R8
                default: ;
            endcase
        end
        if (sfr_rd) begin
            case (sfr_addr)
                P0_SLAVE_ADDR_OFS: rdata_next = port0_slave_address_reg[0];
                P0_ADDR_MASK_OFS: rdata_next = port0_address_mask_reg[0];
                P1_SLAVE_ADDR_OFS: rdata_next = port0_slave_address_reg[1];
                P1_ADDR_MASK_OFS: rdata_next = port0_address_mask_reg[1];
                default: rdata_next = UNMAPPED_RDATA;
            endcase
        end
    end

    // reset leaves every bit don't-care, so any address is taken
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < NPORT; i++) begin
                port0_slave_address_reg[i] <= SLAVE_ADDR_RST; // R6
                port0_address_mask_reg[i] <= ADDR_MASK_RST; // R6
            end
            rdata_reg <= UNMAPPED_RDATA;
        end else begin
            port0_slave_address_reg <= port0_slave_address_next;
            port0_address_mask_reg <= port0_address_mask_next;
            rdata_reg <= rdata_next;
        end
    end

    assign sfr_rdata = rdata_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    // register bus checks
    p0_addr_write_a: assert property ( // R7
        sfr_wr && sfr_addr == P0_SLAVE_ADDR_OFS
        |=> port0_slave_address_reg[0] == $past(sfr_wdata))
        else $error("port 0 address write lost");
    p1_mask_write_a: assert property ( // R8
        sfr_wr && sfr_addr == P1_ADDR_MASK_OFS
        |=> port0_address_mask_reg[1] == $past(sfr_wdata)
        && port0_address_mask_reg[0] == $past(port0_address_mask_reg[0]))
        else $error("port 1 mask write wrong");
    mask_readback_a: assert property ( // R7
        sfr_rd && sfr_addr == P0_ADDR_MASK_OFS
        |=> sfr_rdata == $past(port0_address_mask_reg[0]))
        else $error("port 0 mask read wrong");

    // ************************************************
    // per-port recognition, flag and buffer
    // ************************************************
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        logic [7:0] bcast;
        logic given_hit, bcast_hit, addr_hit, pass, take, set_flag;
        logic flag_reg, flag_next;

        // compare the completed frame against both addresses
        always_comb begin
            given_hit = ((frame_data[p] ^ port0_slave_address_reg[p]) & port0_address_mask_reg[p])
                == 8'h00; // R4
            bcast = port0_slave_address_reg[p] | port0_address_mask_reg[p]; // R5
            bcast_hit = (~frame_data[p] & bcast) == 8'h00; // R5
            addr_hit = given_hit | bcast_hit; // R13
            // ninth bit or stop bit marks an address frame
            pass = (uart_mode[p] == UART_MODE0) || !multiproc_enable[p] // R2
                || (frame_bit9[p] && addr_hit); // R1 R3 R11
        end

        assign take = frame_valid[p] & frame_ready[p];
        assign set_flag = take & pass;

        // sticky flag; a set in the clearing cycle wins
        always_comb begin
            flag_next = set_flag | (flag_reg & ~flag_clr[p]); // R1
        end

        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                flag_reg <= 1'b0;
            end else begin
                flag_reg <= flag_next;
            end
        end

        assign rx_complete_flag[p] = flag_reg;

        // only accepted frames enter the buffer; dropped ones vanish
        uaar_fifo #(
            .WIDTH(RX_WORD_W),
            .DEPTH(FIFO_DEPTH)
        ) u_fifo (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .in_valid(frame_valid[p] & pass),
            .in_ready(frame_ready[p]),
            .in_data({frame_bit9[p], frame_data[p]}),
            .out_valid(rx_valid[p]),
            .out_ready(rx_ready[p]),
            .out_data(rx_data[p])
        );

        given_match_a: assert property ( // R4
            take && multiproc_enable[p] && uart_mode[p][1] && frame_bit9[p]
            && ((frame_data[p] ^ port0_slave_address_reg[p]) & port0_address_mask_reg[p]) == 8'h00
            |=> flag_reg)
            else $error("given address match did not set flag");
        bcast_match_a: assert property ( // R5
            take && multiproc_enable[p] && frame_bit9[p]
            && (frame_data[p] & (port0_slave_address_reg[p] | port0_address_mask_reg[p]))
               == (port0_slave_address_reg[p] | port0_address_mask_reg[p])
            |=> flag_reg)
            else $error("broadcast match did not set flag");
        no_match_drop_a: assert property ( // R1
            take && multiproc_enable[p] && uart_mode[p] != UART_MODE0
            && ((frame_data[p] ^ port0_slave_address_reg[p]) & port0_address_mask_reg[p]) != 8'h00
            && (~frame_data[p] & (port0_slave_address_reg[p] | port0_address_mask_reg[p])) != 8'h00
            && (!flag_reg || flag_clr[p])
            |=> !flag_reg)
            else $error("unmatched address set the flag");
        bit9_zero_a: assert property ( // R11
            take && multiproc_enable[p] && uart_mode[p][1] && !frame_bit9[p]
            && !flag_reg
            |=> !flag_reg ##1 1)
            else $error("data frame set flag under multiproc");
        bad_stop_a: assert property ( // R3
            take && multiproc_enable[p] && uart_mode[p] == UART_MODE1
            && !frame_bit9[p] && (!flag_reg || flag_clr[p])
            |=> !flag_reg)
            else $error("mode 1 bad stop set the flag");
        mpe_off_a: assert property ( // R2
            take && !multiproc_enable[p] |=> flag_reg)
            else $error("frame lost with multiproc off");
        reset_any_a: assert property ( // R6
            take && port0_slave_address_reg[p] == 8'h00 && port0_address_mask_reg[p] == 8'h00
            && frame_bit9[p]
            |=> flag_reg)
            else $error("cleared address refused a frame");
        set_wins_a: assert property ( // R13
            set_flag && flag_clr[p] |=> flag_reg [*1] ##0 rx_valid[p])
            else $error("flag clear beat a new frame");

        addr_hit_c: cover property (
            take && multiproc_enable[p] && frame_bit9[p] && given_hit
            && port0_address_mask_reg[p] != 8'h00);
        addr_drop_c: cover property (
            frame_valid[p] && multiproc_enable[p] && !pass);
        fifo_full_c: cover property (frame_valid[p] && !frame_ready[p]);
    end

endmodule // uaar_top

// *** testbench/uaar_master.sv ***
// remote uart master model offering received frames to one port
`timescale 1ns/1ps
module uaar_master (
    input wire logic clk_sys,
    input wire logic frame_ready,
    output logic frame_valid,
    output logic [7:0] frame_data,
    output logic frame_bit9
);
    // idle lines at time zero
    initial begin
        frame_valid = 1'b0;
        frame_data = 8'h00;
        frame_bit9 = 1'b0;
    end

    // hold one frame until taken, then scramble the released lines
    task automatic send(input logic [7:0] d, input logic b9);
        frame_valid <= 1'b1;
        frame_data <= d;
        frame_bit9 <= b9;
        @(posedge clk_sys);
        while (frame_ready !== 1'b1) @(posedge clk_sys);
        frame_valid <= 1'b0;
        frame_data <= ~d;
        frame_bit9 <= ~b9;
    endtask
endmodule // uaar_master

// *** testbench/uart_auto_address_recognition_test.sv ***
// self-checking bench of the two-port address filter
`timescale 1ns/1ps
module uart_auto_address_recognition_test;
    import uaar_pkg::*;
    logic clk_sys, arst_n, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [1:0][1:0] uart_mode;
    logic [1:0] multiproc_enable, frame_ready;
    wire logic [1:0] frame_valid, frame_bit9;
    logic [1:0] flag_clr, rx_complete_flag, rx_valid, rx_ready;
    wire logic [1:0][7:0] frame_data;
    logic [1:0][8:0] rx_data;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    uaar_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .uart_mode(uart_mode),
        .multiproc_enable(multiproc_enable), .frame_valid(frame_valid),
        .frame_ready(frame_ready), .frame_data(frame_data),
        .frame_bit9(frame_bit9), .flag_clr(flag_clr),
        .rx_complete_flag(rx_complete_flag), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_data(rx_data));
    uaar_master m0 (.clk_sys(clk_sys), .frame_ready(frame_ready[0]),
        .frame_valid(frame_valid[0]), .frame_data(frame_data[0]),
        .frame_bit9(frame_bit9[0]));
    uaar_master m1 (.clk_sys(clk_sys), .frame_ready(frame_ready[1]),
        .frame_valid(frame_valid[1]), .frame_data(frame_data[1]),
        .frame_bit9(frame_bit9[1]));

    // ************************************************
    // clock, timeout and reporting
    // ************************************************
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    // cut a hang short
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ************************************************
    // bus and frame tasks
    // ************************************************
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        @(negedge clk_sys);
        chk_val({1'b0, sfr_rdata}, {1'b0, exp});
    endtask

    // clear the flag, send one frame, judge flag and buffered word
    task automatic frame(input int p, input logic [1:0] m, input logic en,
        input logic [7:0] d, input logic b9, input logic pass);
        @(posedge clk_sys);
        uart_mode[p] <= m;
        multiproc_enable[p] <= en;
        flag_clr[p] <= 1'b1;
        @(posedge clk_sys);
        flag_clr[p] <= 1'b0;
        if (p == 0) m0.send(d, b9);
        else m1.send(d, b9);
        @(negedge clk_sys);
        chk_flag(rx_complete_flag[p], pass);
        chk_flag(rx_valid[p], pass);
        if (pass) chk_val(rx_data[p], {b9, d});
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    task automatic port0_test();
        rd_chk(P0_SLAVE_ADDR_OFS, 8'h00);
        rd_chk(P0_ADDR_MASK_OFS, 8'h00);
        rd_chk(P1_SLAVE_ADDR_OFS, 8'h00);
        rd_chk(P1_ADDR_MASK_OFS, 8'h00);
        frame(0, 2'h2, 1'b1, 8'h5A, 1'b1, 1'b1);
        wr(8'hA8, 8'h77);
        rd_chk(8'hA8, UNMAPPED_RDATA);
        wr(P0_SLAVE_ADDR_OFS, 8'hC0);
        wr(P0_ADDR_MASK_OFS, 8'hFD);
        rd_chk(P0_SLAVE_ADDR_OFS, 8'hC0);
        rd_chk(P0_ADDR_MASK_OFS, 8'hFD);
        frame(0, 2'h2, 1'b1, 8'hC0, 1'b1, 1'b1);
        frame(0, 2'h3, 1'b1, 8'hC2, 1'b1, 1'b1);
        frame(0, 2'h2, 1'b1, 8'hC1, 1'b1, 1'b0);
        frame(0, 2'h2, 1'b1, 8'hFD, 1'b1, 1'b1);
        frame(0, 2'h3, 1'b1, 8'hFF, 1'b1, 1'b1);
        frame(0, 2'h2, 1'b1, 8'hC0, 1'b0, 1'b0);
        frame(0, 2'h2, 1'b0, 8'hC1, 1'b0, 1'b1);
        frame(0, 2'h1, 1'b1, 8'hC0, 1'b1, 1'b1);
        frame(0, 2'h1, 1'b1, 8'hC0, 1'b0, 1'b0);
        frame(0, 2'h1, 1'b1, 8'hC1, 1'b1, 1'b0);
        frame(0, 2'h0, 1'b1, 8'hC1, 1'b0, 1'b1);
    endtask

    task automatic port1_test();
        wr(P1_SLAVE_ADDR_OFS, 8'h12);
        wr(P1_ADDR_MASK_OFS, 8'hFF);
        rd_chk(P1_SLAVE_ADDR_OFS, 8'h12);
        rd_chk(P1_ADDR_MASK_OFS, 8'hFF);
        rd_chk(P0_SLAVE_ADDR_OFS, 8'hC0);
        frame(1, 2'h2, 1'b1, 8'h12, 1'b1, 1'b1);
        frame(1, 2'h2, 1'b1, 8'hC0, 1'b1, 1'b0);
    endtask

    // fill the buffer with the consumer stalled, then drain in order
    task automatic fifo_test();
        int i;
        @(posedge clk_sys);
        rx_ready <= 2'h0;
        uart_mode[0] <= UART_MODE0;
        for (i = 0; i < RX_FIFO_DEPTH; i++) begin
            m0.send(8'h30 + 8'(i), 1'b0);
            @(posedge clk_sys);
        end
        @(negedge clk_sys);
        chk_flag(frame_ready[0], 1'b0);
        @(posedge clk_sys);
        rx_ready <= 2'h3;
        for (i = 0; i < RX_FIFO_DEPTH; i++) begin
            @(negedge clk_sys);
            chk_val(rx_data[0], {1'b0, 8'h30 + 8'(i)});
        end
        @(negedge clk_sys);
        chk_flag(rx_valid[0], 1'b0);
    endtask

    // a reset in mid-run returns the register pairs to zero
    task automatic reset_test();
        @(posedge clk_sys);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd_chk(P1_SLAVE_ADDR_OFS, SLAVE_ADDR_RST);
        rd_chk(P0_ADDR_MASK_OFS, ADDR_MASK_RST);
    endtask

    // a clear that meets a new accepted frame loses to the set
    task automatic set_wins_test();
        @(posedge clk_sys);
        uart_mode[0] <= 2'h2;
        flag_clr[0] <= 1'b1;
        m0.send(8'hC0, 1'b1);
        flag_clr[0] <= 1'b0;
        @(negedge clk_sys);
        chk_flag(rx_complete_flag[0], 1'b1);
        chk_val(rx_data[0], 9'h1C0);
    endtask

    // reset, then run every scenario
    initial begin
        arst_n = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        uart_mode = '0;
        multiproc_enable = '0;
        flag_clr = '0;
        rx_ready = 2'h3;
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        port0_test();
        port1_test();
        reset_test();
        fifo_test();
        set_wins_test();
        report_and_stop();
    end
endmodule // uart_auto_address_recognition_test
